// ==== dso_pkg.sv ====
package dso_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned FIXED_RELEASE_MS = 100;
  localparam int unsigned HUNDRED_MS_CYCLES = FIXED_RELEASE_MS * 1000 * CLK_MHZ;
  localparam int unsigned TICK_CNT_W = 25;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] OFS_FUNC_SEL = 8'h00;
  localparam logic [7:0] OFS_POLARITY = 8'h04;
  localparam logic [7:0] OFS_HOST_CONTACT = 8'h08;
  localparam logic [7:0] OFS_FREQ_DET1 = 8'h0C;
  localparam logic [7:0] OFS_FREQ_DET2 = 8'h10;
  localparam logic [7:0] OFS_FREQ_LOW45 = 8'h14;
  localparam logic [7:0] OFS_CUR_AGREE = 8'h18;
  localparam logic [7:0] OFS_CUR_AGREE2 = 8'h1C;
  localparam logic [7:0] OFS_LOW_CUR = 8'h20;
  localparam logic [7:0] OFS_UNDERVOLT = 8'h24;
  localparam logic [7:0] OFS_TEMP = 8'h28;
  localparam logic [7:0] OFS_SOURCE = 8'h2C;
  localparam logic [7:0] OFS_STATUS = 8'h30;

  // ****************************************
  // Field ranges (0.1 unit steps) and reset values
  // ****************************************
  localparam logic [15:0] FREQ_LEVEL_MAX = 16'h1766;
  localparam logic [15:0] WIDTH_MIN = 16'h0001;
  localparam logic [15:0] WIDTH_MAX = 16'h00FF;
  localparam logic [15:0] CUR_LEVEL_MIN = 16'h0001;
  localparam logic [15:0] CUR_LEVEL_MAX = 16'h270F;
  localparam logic [15:0] CUR_DELAY_MIN = 16'h0001;
  localparam logic [15:0] CUR_DELAY_MAX = 16'h0064;
  localparam logic [15:0] ZERO16 = 16'h0000;
  localparam logic [15:0] RST_WIDTH = 16'h0001;
  localparam logic [15:0] RST_CUR_LEVEL = 16'h0001;
  localparam logic [15:0] RST_CUR_DELAY = 16'h0001;
  localparam logic [23:0] RST_FUNC_SEL = 24'h00_0000;
  localparam int unsigned NUM_OUTPUTS = 3;
  localparam int unsigned NUM_CODES = 64;

  // ****************************************
  // Status function codes
  // ****************************************
  localparam int unsigned FN_FREQ_AGREE = 2;
  localparam int unsigned FN_SET_FREQ_AGREE = 3;
  localparam int unsigned FN_FREQ_DET1 = 4;
  localparam int unsigned FN_FREQ_DET2 = 5;
  localparam int unsigned FN_OVER_TORQUE = 12;
  localparam int unsigned FN_CUR_AGREE = 13;
  localparam int unsigned FN_PLC_STATUS = 18;
  localparam int unsigned FN_ZERO_SPEED = 20;
  localparam int unsigned FN_READY = 21;
  localparam int unsigned FN_UNDERVOLT = 22;
  localparam int unsigned FN_RUN_SOURCE = 23;
  localparam int unsigned FN_FREQ_SOURCE = 24;
  localparam int unsigned FN_LOW_TORQUE = 25;
  localparam int unsigned FN_REF_LOSS = 26;
  localparam int unsigned FN_MOTOR_TWO = 30;
  localparam int unsigned FN_ZERO_SERVO = 31;
  localparam int unsigned FN_HOST_CONTACT = 32;
  localparam int unsigned FN_FREQ_DET3 = 50;
  localparam int unsigned FN_LOW_CURRENT = 57;
  localparam int unsigned FN_DECEL_DET = 58;
  localparam int unsigned FN_OVER_TEMP = 59;

  localparam logic [1:0] SRC_LOCAL = 2'h0;
  localparam logic [1:0] SRC_PLC = 2'h3;

  typedef enum logic [1:0] {
    CA_IDLE = 2'b00,
    CA_QUALIFY = 2'b01,
    CA_ON = 2'b10,
    CA_RELEASE = 2'b11
  } dso_cur_state_t;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [15:0] clampRange(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
    clampRange = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  function automatic logic [15:0] absDiff(input logic [15:0] a, input logic [15:0] b);
    absDiff = (a > b) ? (a - b) : (b - a);
  endfunction

endpackage

// ==== dso_output_channel.sv ====
`timescale 1ns/1ns
`default_nettype none

module dso_output_channel #(
  parameter int unsigned NUM_CODES = dso_pkg::NUM_CODES
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [7:0] funcCode,
  input wire logic invertSel,
  input wire logic [NUM_CODES-1:0] conditionVec,
  output logic rawStatus,
  output logic outPin
);

  logic codeDefined;
  logic outPin_next;

  // ****************************************
  // Function select and contact polarity
  // ****************************************
  assign codeDefined = (funcCode < 8'(NUM_CODES));
  assign rawStatus = codeDefined ? conditionVec[funcCode[5:0]] : 1'b0;
  assign outPin_next = rawStatus ^ invertSel;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      outPin <= 1'b0;
    end else begin
      outPin <= outPin_next;
    end
  end

endmodule // dso_output_channel

`default_nettype wire

// ==== dso_status_selector.sv ====
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none


module dso_status_selector #(
  parameter int unsigned HUNDRED_MS_CYCLES = dso_pkg::HUNDRED_MS_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] outFreq,
  input wire logic [15:0] freqRef,
  input wire logic [15:0] outCurrent,
  input wire logic [15:0] dcBusVolt,
  input wire logic [15:0] heatSinkTemp,
  input wire logic decelerating,
  input wire logic faultActive,
  input wire logic driveReady,
  input wire logic localRemoteIn,
  input wire logic refLost,
  input wire logic overTorque,
  input wire logic lowTorque,
  input wire logic motorTwoSel,
  input wire logic zeroServoEn,
  input wire logic zeroServoLocked,
  output logic relayOutOne,
  output logic relayOutTwo,
  output logic optocouplerOutOne,
  output logic commandSourceLamp,
  output logic refLossDecelStop,
  output logic [15:0] refLossHoldFreq
);

  localparam int unsigned NO = dso_pkg::NUM_OUTPUTS;

  // ****************************************
  // Register storage
  // ****************************************
  logic [23:0] funcSel_reg;
  logic [2:0] polarity_reg;
  logic [2:0] hostContact_reg;
  logic [15:0] freqLevel_reg, freqWidth_reg;
  logic [15:0] freqLevel2_reg, freqWidth2_reg;
  logic [15:0] freqLevel4_reg, freqLevel5_reg;
  logic [15:0] curLevel_reg, curDelay_reg, curLevel2_reg;
  logic [15:0] lowCurLevel_reg, minFreq_reg;
  logic [15:0] underVolt_reg;
  logic [15:0] tempLevel_reg, tempHyst_reg;
  logic [1:0] runSrc_reg, freqSrc_reg;
  logic lossMode_reg;
  logic [7:0] lossFrac_reg;
  logic [31:0] prdata_next;

  // ****************************************
  // APB decode
  // ****************************************
  logic setupPhase, writeAccess, addrHit;
  logic [31:0] readMux;
  logic [15:0] wrLo, wrHi;
  logic [15:0] curLevel2Eff;
  logic [NO-1:0] rawStatus;

  assign setupPhase = psel && !penable;
  assign writeAccess = psel && penable && pwrite && addrHit;
  assign wrLo = pwdata[15:0];
  assign wrHi = pwdata[31:16];
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addrHit;
  assign curLevel2Eff = (curLevel2_reg > curLevel_reg) ? curLevel_reg : curLevel2_reg;

  assign addrHit = (paddr == dso_pkg::OFS_FUNC_SEL) || (paddr == dso_pkg::OFS_POLARITY) ||
    (paddr == dso_pkg::OFS_HOST_CONTACT) || (paddr == dso_pkg::OFS_FREQ_DET1) ||
    (paddr == dso_pkg::OFS_FREQ_DET2) || (paddr == dso_pkg::OFS_FREQ_LOW45) ||
    (paddr == dso_pkg::OFS_CUR_AGREE) || (paddr == dso_pkg::OFS_CUR_AGREE2) ||
    (paddr == dso_pkg::OFS_LOW_CUR) || (paddr == dso_pkg::OFS_UNDERVOLT) ||
    (paddr == dso_pkg::OFS_TEMP) || (paddr == dso_pkg::OFS_SOURCE) || (paddr == dso_pkg::OFS_STATUS);

  logic caOn;
  logic det1_reg, det2_reg, det3_reg, overTemp_reg;

  always_comb begin
    case (paddr)
      dso_pkg::OFS_FUNC_SEL: readMux = {8'h00, funcSel_reg};
      dso_pkg::OFS_POLARITY: readMux = {29'h0000_0000, polarity_reg};
      dso_pkg::OFS_HOST_CONTACT: readMux = {29'h0000_0000, hostContact_reg};
      dso_pkg::OFS_FREQ_DET1: readMux = {freqWidth_reg, freqLevel_reg};
      dso_pkg::OFS_FREQ_DET2: readMux = {freqWidth2_reg, freqLevel2_reg};
      dso_pkg::OFS_FREQ_LOW45: readMux = {freqLevel5_reg, freqLevel4_reg};
      dso_pkg::OFS_CUR_AGREE: readMux = {curDelay_reg, curLevel_reg};
      dso_pkg::OFS_CUR_AGREE2: readMux = {16'h0000, curLevel2Eff};
      dso_pkg::OFS_LOW_CUR: readMux = {minFreq_reg, lowCurLevel_reg};
      dso_pkg::OFS_UNDERVOLT: readMux = {16'h0000, underVolt_reg};
      dso_pkg::OFS_TEMP: readMux = {tempHyst_reg, tempLevel_reg};
      dso_pkg::OFS_SOURCE: readMux = {lossFrac_reg, 16'h0000, 3'h0, lossMode_reg, freqSrc_reg, runSrc_reg};
      dso_pkg::OFS_STATUS: readMux = {21'h00_0000, overTemp_reg, det3_reg, det2_reg, det1_reg, caOn,
                                      rawStatus, optocouplerOutOne, relayOutTwo, relayOutOne};
      default: readMux = 32'h0000_0000;
    endcase
  end

  assign prdata_next = setupPhase ? readMux : prdata;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= prdata_next;
    end
  end

  // ****************************************
  // Register writes with range clamping of the frequency and current fields
  // ****************************************
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      funcSel_reg <= dso_pkg::RST_FUNC_SEL;
      polarity_reg <= 3'h0;
      hostContact_reg <= 3'h0;
      freqLevel_reg <= dso_pkg::ZERO16;
      freqWidth_reg <= dso_pkg::RST_WIDTH;
      freqLevel2_reg <= dso_pkg::ZERO16;
      freqWidth2_reg <= dso_pkg::RST_WIDTH;
      freqLevel4_reg <= dso_pkg::ZERO16;
      freqLevel5_reg <= dso_pkg::ZERO16;
      curLevel_reg <= dso_pkg::RST_CUR_LEVEL;
      curDelay_reg <= dso_pkg::RST_CUR_DELAY;
      curLevel2_reg <= dso_pkg::ZERO16;
      lowCurLevel_reg <= dso_pkg::ZERO16;
      minFreq_reg <= dso_pkg::ZERO16;
      underVolt_reg <= dso_pkg::ZERO16;
      tempLevel_reg <= dso_pkg::ZERO16;
      tempHyst_reg <= dso_pkg::ZERO16;
      runSrc_reg <= dso_pkg::SRC_LOCAL;
      freqSrc_reg <= dso_pkg::SRC_LOCAL;
      lossMode_reg <= 1'b0;
      lossFrac_reg <= 8'h00;
    end else if (writeAccess) begin
      case (paddr)
        dso_pkg::OFS_FUNC_SEL: funcSel_reg <= pwdata[23:0];
        dso_pkg::OFS_POLARITY: polarity_reg <= pwdata[2:0];
        dso_pkg::OFS_HOST_CONTACT: hostContact_reg <= pwdata[2:0];
        dso_pkg::OFS_FREQ_DET1: begin
          freqLevel_reg <= dso_pkg::clampRange(wrLo, dso_pkg::ZERO16, dso_pkg::FREQ_LEVEL_MAX);
          freqWidth_reg <= dso_pkg::clampRange(wrHi, dso_pkg::WIDTH_MIN, dso_pkg::WIDTH_MAX);
        end
        dso_pkg::OFS_FREQ_DET2: begin
          freqLevel2_reg <= dso_pkg::clampRange(wrLo, dso_pkg::ZERO16, dso_pkg::FREQ_LEVEL_MAX);
          freqWidth2_reg <= dso_pkg::clampRange(wrHi, dso_pkg::WIDTH_MIN, dso_pkg::WIDTH_MAX);
        end
        dso_pkg::OFS_FREQ_LOW45: begin
          freqLevel4_reg <= dso_pkg::clampRange(wrLo, dso_pkg::ZERO16, dso_pkg::FREQ_LEVEL_MAX);
          freqLevel5_reg <= dso_pkg::clampRange(wrHi, dso_pkg::ZERO16, dso_pkg::FREQ_LEVEL_MAX);
        end
        dso_pkg::OFS_CUR_AGREE: begin
          curLevel_reg <= dso_pkg::clampRange(wrLo, dso_pkg::CUR_LEVEL_MIN, dso_pkg::CUR_LEVEL_MAX);
          curDelay_reg <= dso_pkg::clampRange(wrHi, dso_pkg::CUR_DELAY_MIN, dso_pkg::CUR_DELAY_MAX);
        end
        dso_pkg::OFS_CUR_AGREE2: curLevel2_reg <= (wrLo > curLevel_reg) ? curLevel_reg : wrLo;
        dso_pkg::OFS_LOW_CUR: begin
          lowCurLevel_reg <= dso_pkg::clampRange(wrLo, dso_pkg::ZERO16, dso_pkg::CUR_LEVEL_MAX);
          minFreq_reg <= dso_pkg::clampRange(wrHi, dso_pkg::ZERO16, dso_pkg::FREQ_LEVEL_MAX);
        end
        dso_pkg::OFS_UNDERVOLT: underVolt_reg <= wrLo;
        dso_pkg::OFS_TEMP: begin
          tempLevel_reg <= wrLo;
          tempHyst_reg <= wrHi;
        end
        dso_pkg::OFS_SOURCE: begin
          runSrc_reg <= pwdata[1:0];
          freqSrc_reg <= pwdata[3:2];
          lossMode_reg <= pwdata[4];
          lossFrac_reg <= pwdata[31:24];
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // Frequency and temperature comparisons
  // ****************************************
  logic [16:0] lvlPlusW, lvl2PlusW2, refMinusW, tempPlusHyst;
  logic [16:0] outFreqX, heatX;

  assign outFreqX = {1'b0, outFreq};
  assign heatX = {1'b0, heatSinkTemp};
  assign lvlPlusW = {1'b0, freqLevel_reg} + {1'b0, freqWidth_reg};
  assign lvl2PlusW2 = {1'b0, freqLevel2_reg} + {1'b0, freqWidth2_reg};
  assign refMinusW = {1'b0, freqRef} - {1'b0, freqWidth_reg};
  assign tempPlusHyst = heatX + {1'b0, tempHyst_reg};

  logic det1_next, det2_next, det3_next, overTemp_next;

  assign det1_next = (outFreqX > lvlPlusW) ? 1'b1 : ((outFreq < freqLevel_reg) ? 1'b0 : det1_reg);
  assign det2_next = (outFreqX > lvlPlusW) ? 1'b0 : ((outFreq < freqLevel4_reg) ? 1'b1 : det2_reg);
  assign det3_next = (outFreqX > lvl2PlusW2) ? 1'b1 : ((outFreq < freqLevel5_reg) ? 1'b0 : det3_reg);
  assign overTemp_next = (heatSinkTemp > tempLevel_reg) ? 1'b1 :
                         ((tempPlusHyst < {1'b0, tempLevel_reg}) ? 1'b0 : overTemp_reg);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      det1_reg <= 1'b0;
      det2_reg <= 1'b0;
      det3_reg <= 1'b0;
      overTemp_reg <= 1'b0;
    end else begin
      det1_reg <= det1_next;
      det2_reg <= det2_next;
      det3_reg <= det3_next;
      overTemp_reg <= overTemp_next;
    end
  end

  // ****************************************
  // Current agree with qualify and release timing
  // ****************************************
  dso_pkg::dso_cur_state_t caState_reg, caState_next;
  logic [dso_pkg::TICK_CNT_W-1:0] prescale_reg, prescale_next;
  logic [7:0] tenths_reg, tenths_next;
  logic curAbove, curBelow2, prescaleDone;

  assign curAbove = outCurrent > curLevel_reg;
  assign curBelow2 = outCurrent <= curLevel2Eff;
  assign prescaleDone = (prescale_reg == dso_pkg::TICK_CNT_W'(HUNDRED_MS_CYCLES - 1));
  assign caOn = (caState_reg == dso_pkg::CA_ON) || (caState_reg == dso_pkg::CA_RELEASE);

  always_comb begin
    caState_next = caState_reg;
    prescale_next = prescaleDone ? '0 : prescale_reg + 1'b1;
    tenths_next = tenths_reg;
    case (caState_reg)
      dso_pkg::CA_IDLE: begin
        prescale_next = '0;
        tenths_next = 8'h00;
        if (curAbove) begin
          caState_next = dso_pkg::CA_QUALIFY;
        end
      end
      dso_pkg::CA_QUALIFY: begin
        if (!curAbove) begin
          caState_next = dso_pkg::CA_IDLE;
        end else if (tenths_reg > curDelay_reg[7:0]) begin
          caState_next = dso_pkg::CA_ON;
        end else if (prescaleDone) begin
          tenths_next = tenths_reg + 8'h01;
        end
      end
      dso_pkg::CA_ON: begin
        prescale_next = '0;
        if (curBelow2) begin
          caState_next = dso_pkg::CA_RELEASE;
        end
      end
      dso_pkg::CA_RELEASE: begin
        if (!curBelow2) begin
          caState_next = dso_pkg::CA_ON;
        end else if (prescaleDone) begin
          caState_next = dso_pkg::CA_IDLE;
        end
      end
      default: caState_next = dso_pkg::CA_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      caState_reg <= dso_pkg::CA_IDLE;
      prescale_reg <= '0;
      tenths_reg <= 8'h00;
    end else begin
      caState_reg <= caState_next;
      prescale_reg <= prescale_next;
      tenths_reg <= tenths_next;
    end
  end

  // ****************************************
  // Reference loss handling
  // ****************************************
  logic [15:0] lastRef_reg;
  logic [23:0] holdProduct;

  assign holdProduct = lastRef_reg * lossFrac_reg;
  assign refLossDecelStop = refLost && !lossMode_reg;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      lastRef_reg <= 16'h0000;
      refLossHoldFreq <= 16'h0000;
    end else begin
      if (!refLost) begin
        lastRef_reg <= freqRef;
      end
      refLossHoldFreq <= (refLost && lossMode_reg) ? holdProduct[23:8] : 16'h0000;
    end
  end

  // ****************************************
  // Condition vector
  // ****************************************
  logic [dso_pkg::NUM_CODES-1:0] condCommon;
  logic localRun, localFreq;

  assign localRun = (runSrc_reg == dso_pkg::SRC_LOCAL) || localRemoteIn;
  assign localFreq = (freqSrc_reg == dso_pkg::SRC_LOCAL) || localRemoteIn;
  assign commandSourceLamp = !localRun;

  always_comb begin
    condCommon = '0;
    condCommon[dso_pkg::FN_FREQ_AGREE] = dso_pkg::absDiff(outFreq, freqRef) <= freqWidth_reg;
    condCommon[dso_pkg::FN_SET_FREQ_AGREE] = dso_pkg::absDiff(outFreq, freqLevel_reg) <= freqWidth_reg;
    condCommon[dso_pkg::FN_FREQ_DET1] = det1_reg;
    condCommon[dso_pkg::FN_FREQ_DET2] = det2_reg;
    condCommon[dso_pkg::FN_OVER_TORQUE] = overTorque;
    condCommon[dso_pkg::FN_CUR_AGREE] = caOn;
    condCommon[dso_pkg::FN_PLC_STATUS] = (runSrc_reg == dso_pkg::SRC_PLC);
    condCommon[dso_pkg::FN_ZERO_SPEED] = outFreq <= minFreq_reg;
    condCommon[dso_pkg::FN_READY] = !faultActive && driveReady;
    condCommon[dso_pkg::FN_UNDERVOLT] = dcBusVolt < underVolt_reg;
    condCommon[dso_pkg::FN_RUN_SOURCE] = localRun;
    condCommon[dso_pkg::FN_FREQ_SOURCE] = localFreq;
    condCommon[dso_pkg::FN_LOW_TORQUE] = lowTorque;
    condCommon[dso_pkg::FN_REF_LOSS] = refLost;
    condCommon[dso_pkg::FN_MOTOR_TWO] = motorTwoSel;
    condCommon[dso_pkg::FN_ZERO_SERVO] = zeroServoEn && zeroServoLocked;
    condCommon[dso_pkg::FN_FREQ_DET3] = det3_reg;
    condCommon[dso_pkg::FN_LOW_CURRENT] = outCurrent <= lowCurLevel_reg;
    condCommon[dso_pkg::FN_DECEL_DET] = decelerating && (outFreqX < refMinusW) && (freqRef >= freqWidth_reg);
    condCommon[dso_pkg::FN_OVER_TEMP] = overTemp_reg;
  end

  // ****************************************
  // Output channels
  // ****************************************
  logic [NO-1:0] outPins;

  for (genvar i = 0; i < NO; i++) begin : gChan
    logic [dso_pkg::NUM_CODES-1:0] condVec;
    always_comb begin
      condVec = condCommon;
      condVec[dso_pkg::FN_HOST_CONTACT] = hostContact_reg[i];
    end
    dso_output_channel #(
      .NUM_CODES(dso_pkg::NUM_CODES)
    ) uChan (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .funcCode(funcSel_reg[8*i +: 8]),
      .invertSel(polarity_reg[i]),
      .conditionVec(condVec),
      .rawStatus(rawStatus[i]),
      .outPin(outPins[i])
    );
  end

  assign relayOutOne = outPins[0];
  assign relayOutTwo = outPins[1];
  assign optocouplerOutOne = outPins[2];

endmodule // dso_status_selector

`default_nettype wire

// ==== dso_status_props.sv ====
`timescale 1ns/1ns
`default_nettype none
module dso_status_props (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic faultActive,
  input wire logic driveReady,
  input wire logic refLost,
  input wire logic overTorque,
  input wire logic motorTwoSel,
  input wire logic zeroServoEn,
  input wire logic zeroServoLocked,
  input wire logic relayOutOne,
  input wire logic optocouplerOutOne,
  input wire logic refLossDecelStop,
  input wire logic [15:0] refLossHoldFreq
);
  // ****************************************
  // Shadow of the selection registers
  // ****************************************
  logic [23:0] funcSel_reg;
  logic [2:0] pol_reg;
  logic [2:0] host_reg;
  wire logic wrEn = psel && penable && pwrite && pready;
  wire logic [7:0] codeOne = funcSel_reg[7:0];
  wire logic [7:0] codeThree = funcSel_reg[23:16];
  wire logic hostOne = host_reg[0] ^ pol_reg[0];
  wire logic hostThree = host_reg[2] ^ pol_reg[2];
  wire logic plainOne = !pol_reg[0];
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      funcSel_reg <= 24'h00_0000;
      pol_reg <= 3'h0;
      host_reg <= 3'h0;
    end else if (wrEn) begin
      if (paddr == dso_pkg::OFS_FUNC_SEL) funcSel_reg <= pwdata[23:0];
      if (paddr == dso_pkg::OFS_POLARITY) pol_reg <= pwdata[2:0];
      if (paddr == dso_pkg::OFS_HOST_CONTACT) host_reg <= pwdata[2:0];
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // ****************************************
  // Output checks
  // ****************************************
  AST_HOST_ONE: assert property (codeOne == 8'h20 |=> relayOutOne == $past(hostOne))
    else $error("relay one differs from host bit");
  AST_HOST_THREE: assert property (codeThree == 8'h20 |=> optocouplerOutOne == $past(hostThree))
    else $error("optocoupler differs from host bit");
  AST_OVER_TORQUE: assert property (codeOne == 8'h0C && plainOne |=> relayOutOne == $past(overTorque))
    else $error("over torque output wrong");
  AST_READY: assert property (codeOne == 8'h15 && plainOne |=> relayOutOne == ($past(driveReady) && !$past(faultActive)))
    else $error("ready output wrong");
  AST_MOTOR_TWO: assert property (codeOne == 8'h1E && plainOne |=> relayOutOne == $past(motorTwoSel))
    else $error("motor two output wrong");
  AST_ZERO_SERVO: assert property (codeOne == 8'h1F && plainOne |=> relayOutOne == ($past(zeroServoEn) && $past(zeroServoLocked)))
    else $error("zero servo output wrong");
  AST_UNDEF_CODE: assert property (codeThree == 8'h00 |=> optocouplerOutOne == $past(pol_reg[2]))
    else $error("undefined code drives output");
  AST_LOSS_STOP: assert property (refLossDecelStop |-> refLost)
    else $error("stop request without reference loss");
  AST_HOLD_ZERO: assert property (!refLost |=> refLossHoldFreq == 16'h0000)
    else $error("hold frequency without reference loss");
endmodule // dso_status_props
bind dso_status_selector dso_status_props i_props (.sys_clk, .rst_b, .paddr, .psel, .penable, .pwrite, .pwdata,
  .pready, .faultActive, .driveReady, .refLost, .overTorque, .motorTwoSel, .zeroServoEn, .zeroServoLocked,
  .relayOutOne, .optocouplerOutOne, .refLossDecelStop, .refLossHoldFreq);
`default_nettype wire

// ==== dso_contact_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module dso_contact_model (
  input wire logic relayOutOne,
  input wire logic relayOutTwo,
  input wire logic optocouplerOutOne,
  output logic [2:0] contactClosed
);
  // Energized coil closes the working contact
  assign contactClosed = {optocouplerOutOne, relayOutTwo, relayOutOne};
endmodule // dso_contact_model
`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, v = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rdData;
  logic [15:0] outFreq = 16'h0000, freqRef = 16'h0064, outCurrent = 16'h0000, dcBusVolt = 16'h0000;
  logic [15:0] heatSinkTemp = 16'h0000, refLossHoldFreq;
  logic pready, pslverr, relayOutOne, relayOutTwo, optocouplerOutOne, commandSourceLamp, refLossDecelStop, rdErr;
  logic [2:0] contactClosed;
  logic [7:0] codes [11] = '{8'h0C, 8'h19, 8'h1E, 8'h15, 8'h1F, 8'h1A, 8'h17, 8'h18, 8'h12, 8'h3F, 8'hC8};
  logic [15:0] freqs [4] = '{16'h006F, 16'h0069, 16'h0063, 16'h0069};
  int num_errors = 0;
  int checks = 0;
  always #2 sys_clk = ~sys_clk;
  dso_status_selector #(.HUNDRED_MS_CYCLES(10)) i_dut (.sys_clk, .rst_b, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .outFreq, .freqRef, .outCurrent, .dcBusVolt, .heatSinkTemp,
    .decelerating(v), .faultActive(~v), .driveReady(v), .localRemoteIn(v), .refLost(v), .overTorque(v),
    .lowTorque(v), .motorTwoSel(v), .zeroServoEn(v), .zeroServoLocked(v), .relayOutOne, .relayOutTwo,
    .optocouplerOutOne, .commandSourceLamp, .refLossDecelStop, .refLossHoldFreq);
  dso_contact_model i_contacts (.relayOutOne, .relayOutTwo, .optocouplerOutOne, .contactClosed);
  // ****************************************
  // Bus and check tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= we;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rdData = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic report_and_stop();
    if (num_errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge sys_clk);
    num_errors++;
    report_and_stop();
  end
  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    xfer(1'b0, dso_pkg::OFS_FUNC_SEL, 32'h0000_0000);
    chk("code reset", rdData, 32'h0000_0000);
    xfer(1'b0, 8'hFC, 32'h0000_0000);
    chk("unmapped error", {31'h0, rdErr}, 32'h0000_0001);
    xfer(1'b1, dso_pkg::OFS_FUNC_SEL, 32'h0020_2020);
    xfer(1'b1, dso_pkg::OFS_HOST_CONTACT, 32'h0000_0005);
    tick(3);
    chk("host contacts", {29'h0, contactClosed}, 32'h0000_0005);
    xfer(1'b1, dso_pkg::OFS_POLARITY, 32'h0000_0007);
    tick(3);
    chk("inverted contacts", {29'h0, contactClosed}, 32'h0000_0002);
    xfer(1'b1, dso_pkg::OFS_POLARITY, 32'h0000_0000);
    xfer(1'b1, dso_pkg::OFS_SOURCE, 32'h0000_0007);
    foreach (codes[i]) begin
      xfer(1'b1, dso_pkg::OFS_FUNC_SEL, {24'h00_0000, codes[i]});
      for (int b = 0; b < 2; b++) begin
        @(posedge sys_clk) v <= b[0];
        tick(3);
        chk("coded status", {31'h0, relayOutOne},
            {31'h0, i < 8 ? b[0] : i == 8});
        chk("lamp", {31'h0, commandSourceLamp}, {31'h0, ~b[0]});
        chk("loss stop", {31'h0, refLossDecelStop}, {31'h0, b[0]});
      end
    end
    xfer(1'b1, dso_pkg::OFS_SOURCE, 32'h8000_0017);
    tick(2);
    chk("hold freq", {16'h0, refLossHoldFreq}, 32'h0000_0032);
    xfer(1'b1, dso_pkg::OFS_CUR_AGREE, 32'h00C8_0000);
    xfer(1'b0, dso_pkg::OFS_CUR_AGREE, 32'h0000_0000);
    chk("current clamp", rdData, 32'h0064_0001);
    xfer(1'b1, dso_pkg::OFS_CUR_AGREE, 32'h0001_0064);
    xfer(1'b1, dso_pkg::OFS_CUR_AGREE2, 32'h0000_01F4);
    xfer(1'b0, dso_pkg::OFS_CUR_AGREE2, 32'h0000_0000);
    chk("level two clamp", rdData, 32'h0000_0064);
    xfer(1'b1, dso_pkg::OFS_CUR_AGREE2, 32'h0000_0032);
    xfer(1'b1, dso_pkg::OFS_FUNC_SEL, 32'h0000_000D);
    @(posedge sys_clk) outCurrent <= 16'h00C8;
    tick(8);
    chk("agree early", {31'h0, relayOutOne}, 32'h0000_0000);
    tick(30);
    chk("agree on", {31'h0, relayOutOne}, 32'h0000_0001);
    @(posedge sys_clk) outCurrent <= 16'h0050;
    tick(20);
    chk("agree above level two", {31'h0, relayOutOne}, 32'h0000_0001);
    @(posedge sys_clk) outCurrent <= 16'h0028;
    tick(5);
    chk("agree release wait", {31'h0, relayOutOne}, 32'h0000_0001);
    tick(12);
    chk("agree released", {31'h0, relayOutOne}, 32'h0000_0000);
    xfer(1'b1, dso_pkg::OFS_LOW_CUR, 32'h0032_0064);
    xfer(1'b1, dso_pkg::OFS_UNDERVOLT, 32'h0000_012C);
    xfer(1'b1, dso_pkg::OFS_FUNC_SEL, 32'h0039_1416);
    for (int k = 0; k < 2; k++) begin
      @(posedge sys_clk);
      outFreq <= 16'h0032 + 16'(k);
      outCurrent <= 16'h0064 + 16'(k);
      dcBusVolt <= 16'h012B + 16'(k);
      tick(3);
      chk("threshold outputs", {29'h0, contactClosed}, (k == 0) ? 32'h0000_0007 : 32'h0000_0000);
    end
    xfer(1'b1, dso_pkg::OFS_FREQ_DET1, 32'h000A_0064);
    xfer(1'b1, dso_pkg::OFS_FUNC_SEL, 32'h0003_0204);
    foreach (freqs[i]) begin
      @(posedge sys_clk) outFreq <= freqs[i];
      tick(4);
      chk("detect one", {31'h0, relayOutOne}, {31'h0, i < 2});
      chk("agree pair", {30'h0, contactClosed[2:1]}, (i == 0) ? 32'h0000_0000 : 32'h0000_0003);
    end
    xfer(1'b1, dso_pkg::OFS_TEMP, 32'h0005_0064);
    xfer(1'b1, dso_pkg::OFS_FUNC_SEL, 32'h0000_3A3B);
    @(posedge sys_clk) heatSinkTemp <= 16'h0065;
    outFreq <= 16'h0050;
    tick(3);
    chk("temp decel", {30'h0, contactClosed[1:0]}, 32'h0000_0003);
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
